//--- logic/eeprom_pkg.sv
package eeprom_pkg;

  // opcodes; bit 3 of read and write carries the ninth address bit
  localparam logic [7:0] OP_SET_LATCH  = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OP_RD_STAT    = 8'h05;
  localparam logic [7:0] OP_WR_STAT    = 8'h01;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_WRITE      = 8'h02;
  localparam logic [7:0] OP_ADDR_MASK  = 8'hf7;
  localparam int         NINTH_BIT_POS = 3;

  // status field positions and reset value
  localparam int         BUSY_POS      = 0;
  localparam int         LATCH_POS     = 1;
  localparam int         LEVEL_POS     = 2;
  localparam int         DOG_POS       = 4;
  localparam logic [7:0] STATUS_RESET  = 8'h30;
  localparam logic [1:0] LEVEL_RESET   = STATUS_RESET[LEVEL_POS+:2];
  localparam logic [1:0] DOG_RESET     = STATUS_RESET[DOG_POS+:2];

  // array geometry and protected region starts
  localparam int         MEM_DEPTH     = 512;
  localparam int         PAGE_BYTES    = 16;
  localparam logic [8:0] PROT_QTR_BASE = 9'h180;
  localparam logic [8:0] PROT_HLF_BASE = 9'h100;

  // default length of the modelled nonvolatile write, in clocks
  localparam int         WRITE_CYCLES_DEF = 1024;

  // true when an array address is locked at this protection level
  function automatic logic prot_hit(input logic [1:0] lvl, input logic [8:0] a);
    case (lvl)
      2'b01:   prot_hit = (a >= PROT_QTR_BASE);
      2'b10:   prot_hit = (a >= PROT_HLF_BASE);
      2'b11:   prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

endpackage : eeprom_pkg

//--- logic/byte_stream_if.sv
`timescale 1ns/1ps
// one byte wide valid/ready stream between internal stages
interface byte_stream_if;
  logic [7:0] data;  // byte payload
  logic       valid; // payload present
  logic       ready; // sink takes it this cycle
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

//--- logic/spi_pin_front.sv
`timescale 1ns/1ps
module spi_pin_front
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // raw pins
  input  wire logic  sck_in,
  input  wire logic  cs_n_in,
  input  wire logic  si_in,
  input  wire logic  wp_n_in,
  // recovered events
  output logic       sck_fall_out,
  output logic       cs_low_out,
  output logic       frame_end_out,
  output logic       aligned_out,
  output logic       wp_low_out,
  // received bytes
  byte_stream_if.src rx
);

  logic [3:0] raw;           // pins gathered for the synchroniser
  logic [3:0] meta_reg;      // first stage, read only by sync_reg
  logic [3:0] sync_reg;      // second stage
  logic       sck_prev_reg;  // for edge finding
  logic       cs_prev_reg;
  logic [2:0] bit_cnt_reg;   // bits taken in the current byte
  logic [6:0] shift_reg;     // partial byte, msb first
  logic [7:0] data_reg;
  logic       valid_reg;
  logic       sck_rise;

  assign raw = {wp_n_in, si_in, cs_n_in, sck_in};

  // two flops per pin, one lane each
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end
        else
        begin
          meta_reg[g] <= raw[g];
          sync_reg[g] <= meta_reg[g];
        end
    end
  endgenerate

  // previous synchronised levels for edge detection
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= sync_reg[0];
      cs_prev_reg  <= sync_reg[1];
    end

  assign sck_rise      = sync_reg[0] & ~sck_prev_reg & ~sync_reg[1];
  assign sck_fall_out  = ~sync_reg[0] & sck_prev_reg & ~sync_reg[1];
  assign cs_low_out    = ~sync_reg[1];
  assign frame_end_out = sync_reg[1] & ~cs_prev_reg;
  assign aligned_out   = (bit_cnt_reg == 3'd0); // still last frame's count on frame end
  assign wp_low_out    = ~sync_reg[3];

  // input shifter, sampled on rising clock, msb first
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      bit_cnt_reg <= 3'd0;
      shift_reg   <= 7'h00;
    end
    else if (!cs_low_out)
      bit_cnt_reg <= 3'd0;
    else if (sck_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      shift_reg   <= {shift_reg[5:0], sync_reg[2]};
    end

  // completed byte waits here until the buffer takes it
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      data_reg  <= 8'h00;
      valid_reg <= 1'b0;
    end
    else if (sck_rise && bit_cnt_reg == 3'd7)
    begin
      data_reg  <= {shift_reg, sync_reg[2]};
      valid_reg <= 1'b1;
    end
    else if (rx.ready)
      valid_reg <= 1'b0;

  assign rx.data  = data_reg;
  assign rx.valid = valid_reg;

endmodule : spi_pin_front

//--- logic/byte_fifo2.sv
`timescale 1ns/1ps
module byte_fifo2
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // drops contents between frames
  input  wire logic  flush_in,
  // fill and drain sides
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);

  logic [7:0] slot_reg [2]; // two entries
  logic       wp_reg;       // write pointer
  logic       rp_reg;       // read pointer
  logic [1:0] cnt_reg;      // occupancy 0..2
  logic       push;
  logic       pop;

  assign wr.ready = (cnt_reg != 2'd2);
  assign rd.valid = (cnt_reg != 2'd0);
  assign rd.data  = slot_reg[rp_reg];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // pointers and count; a stalled drain lets it fill honestly
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else if (flush_in)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else
    begin
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'd1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'd1;
    end

  // storage needs no reset
  always_ff @(posedge clk_in)
    if (push)
      slot_reg[wp_reg] <= wr.data;

endmodule : byte_fifo2

//--- logic/spi_eeprom_command_protect.sv
// Functional notes
// - writes accepted only with latch set
// - set and clear commands drive latch
// - latch clears after any write cycle
// - write-protect pin low clears latch
// - latch and status-read commands are opcode-only
// - status layout, default value 30h
// - busy bit shows nonvolatile write
// - latch bit mirrors the latch
// - protected bytes readable, never written
// - protection level selects locked range
// - watchdog period bits select timeout
// - status readable anytime, even busy
// - status write needs fresh frame
// - latch and pin gate all writes
// - read opcode bit 3 is ninth address
// - read increments address, wraps to zero
// - read lasts until chip select rises
// - array write needs fresh frame
// - array write spans at least 24 clocks
// - page write wraps in 16 bytes
// - commit only on byte-aligned select rise
// - opcode encodings
// - sample on rise, drive after fall
// - most significant bit first
`timescale 1ns/1ps
module spi_eeprom_command_protect
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF // nonvolatile write length
)
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // serial link pins
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic            so_oe_out,
  // write protect pin
  input  wire logic       wp_n_in,
  // state shown to the system
  output logic [1:0]      dog_period_out,
  output logic            busy_out
);

  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_RDATA, ST_RSTAT, ST_WDATA, ST_WSTAT, ST_WSDONE, ST_IGNORE
  } state_t;

  byte_stream_if rx_raw ();   // shifter to buffer
  byte_stream_if rx_buf ();   // buffer to command engine

  logic       sck_fall;       // synchronised clock fall, inside a frame
  logic       cs_low;
  logic       frame_end;
  logic       aligned;        // select rose on a byte boundary
  logic       wp_low;
  state_t     state_reg;
  logic       is_wr_reg;      // current opcode is an array write
  logic [8:0] addr_reg;
  logic       latch_reg;
  logic [1:0] level_reg;      // nonvolatile protection level
  logic [1:0] dog_reg;        // nonvolatile watchdog period
  logic [7:0] stat_data_reg;  // byte captured by a status write
  logic [7:0] page_buf [PAGE_BYTES];
  logic [15:0] mask_reg;      // page bytes loaded this frame
  logic [4:0] page_base_reg;  // page being committed
  logic       busy_reg;
  logic       busy_arr_reg;   // busy cycle belongs to array write
  logic [15:0] busy_cnt_reg;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] tx_byte_reg;    // remaining bits of the byte on so
  logic [2:0] tx_bit_reg;
  logic       so_reg;
  logic       so_oe_reg;
  logic [7:0] stat_word;
  logic [7:0] tx_src;
  logic [7:0] tx_cur;
  logic [7:0] rx_byte;
  logic       pop;
  logic       write_ok;
  logic       busy_end;
  logic       commit_arr;
  logic       commit_st;

  // pin recovery and byte assembly
  spi_pin_front u_front (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .sck_in        (sck_in),
    .cs_n_in       (cs_n_in),
    .si_in         (si_in),
    .wp_n_in       (wp_n_in),
    .sck_fall_out  (sck_fall),
    .cs_low_out    (cs_low),
    .frame_end_out (frame_end),
    .aligned_out   (aligned),
    .wp_low_out    (wp_low),
    .rx            (rx_raw.src)
  );

  // two-entry buffer, flushed when a frame ends
  byte_fifo2 u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .flush_in (frame_end),
    .wr       (rx_raw.snk),
    .rd       (rx_buf.src)
  );

  // engine stalls in the last busy cycle of any write, when the write cycle ends and the latch clears
  assign rx_buf.ready = ~busy_end;
  assign rx_byte      = rx_buf.data;
  assign pop          = rx_buf.valid & rx_buf.ready;
  assign busy_end     = busy_reg & (busy_cnt_reg == 16'h0000);
  assign write_ok     = latch_reg & ~wp_low & ~busy_reg;
  // a write commits only on an aligned rise after whole data bytes
  assign commit_arr   = frame_end & aligned & (state_reg == ST_WDATA)
                      & (|mask_reg) & write_ok;
  assign commit_st    = frame_end & aligned & (state_reg == ST_WSDONE)
                      & write_ok;
  assign stat_word    = {2'b00, dog_reg, level_reg, latch_reg, busy_reg};

  // command sequencing, one opcode per frame
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      state_reg <= ST_OPC;
      is_wr_reg <= 1'b0;
    end
    else if (frame_end)
      state_reg <= ST_OPC;
    else if (pop)
      case (state_reg)
        ST_OPC:
        begin
          is_wr_reg <= ((rx_byte & OP_ADDR_MASK) == OP_WRITE);
          if (rx_byte == OP_RD_STAT)
            state_reg <= ST_RSTAT;
          else if (rx_byte == OP_WR_STAT)
            state_reg <= write_ok ? ST_WSTAT : ST_IGNORE;
          else if ((rx_byte & OP_ADDR_MASK) == OP_READ)
            state_reg <= ST_ADDR;
          else if ((rx_byte & OP_ADDR_MASK) == OP_WRITE)
            state_reg <= write_ok ? ST_ADDR : ST_IGNORE;
          else
            state_reg <= ST_IGNORE;
        end
        ST_ADDR:   state_reg <= is_wr_reg ? ST_WDATA : ST_RDATA;
        ST_WSTAT:  state_reg <= ST_WSDONE;
        ST_WSDONE: state_reg <= ST_IGNORE;  // a further byte cancels the status write
        default:   state_reg <= state_reg;
      endcase

  // address: ninth bit from opcode, page wrap on write, full wrap on read
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      addr_reg <= 9'h000;
    else if (pop && state_reg == ST_OPC)
      addr_reg[8] <= rx_byte[NINTH_BIT_POS];
    else if (pop && state_reg == ST_ADDR)
      addr_reg[7:0] <= rx_byte;
    else if (pop && state_reg == ST_WDATA)
      addr_reg[3:0] <= addr_reg[3:0] + 4'd1;
    else if (sck_fall && state_reg == ST_RDATA && tx_bit_reg == 3'd7)
      addr_reg <= addr_reg + 9'd1;

  // page buffer load; later bytes overwrite earlier ones at the same slot
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      mask_reg <= 16'h0000;
    else if (pop && state_reg == ST_OPC && write_ok
             && (rx_byte & OP_ADDR_MASK) == OP_WRITE)
      mask_reg <= 16'h0000;
    else if (pop && state_reg == ST_WDATA)
      mask_reg[addr_reg[3:0]] <= 1'b1;

  always_ff @(posedge clk_in)
    if (pop && state_reg == ST_WDATA)
      page_buf[addr_reg[3:0]] <= rx_byte;

  // status write data capture
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      stat_data_reg <= 8'h00;
    else if (pop && state_reg == ST_WSTAT)
      stat_data_reg <= rx_byte;

  // busy counter models the nonvolatile write time
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      busy_reg      <= 1'b0;
      busy_arr_reg  <= 1'b0;
      busy_cnt_reg  <= 16'h0000;
      page_base_reg <= 5'h00;
    end
    else if (commit_arr || commit_st)
    begin
      busy_reg      <= 1'b1;
      busy_arr_reg  <= commit_arr;
      busy_cnt_reg  <= 16'(WRITE_CYCLES - 1);
      page_base_reg <= addr_reg[8:4];
    end
    else if (busy_end)
      busy_reg <= 1'b0;
    else if (busy_reg)
      busy_cnt_reg <= busy_cnt_reg - 16'h0001;

  // write enable latch; pin low wins over everything
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      latch_reg <= 1'b0;
    else if (wp_low)
      latch_reg <= 1'b0;
    else if (busy_end)
      latch_reg <= 1'b0;
    else if (pop && state_reg == ST_OPC && rx_byte == OP_SET_LATCH)
      latch_reg <= 1'b1;
    else if (pop && state_reg == ST_OPC && rx_byte == OP_CLR_LATCH)
      latch_reg <= 1'b0;

  // nonvolatile bits change only at the end of a status write
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      level_reg <= LEVEL_RESET;
      dog_reg   <= DOG_RESET;
    end
    else if (busy_end && !busy_arr_reg)
    begin
      level_reg <= stat_data_reg[LEVEL_POS+:2];
      dog_reg   <= stat_data_reg[DOG_POS+:2];
    end

  // array commit; locked bytes are skipped, not refused as a whole
  always_ff @(posedge clk_in)
    if (busy_end && busy_arr_reg)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (mask_reg[i] && !prot_hit(level_reg, {page_base_reg, 4'(i)}))
          mem[{page_base_reg, 4'(i)}] <= page_buf[i];

  // output byte source; status may be read while busy
  assign tx_src = (state_reg == ST_RSTAT) ? stat_word : mem[addr_reg];
  assign tx_cur = (tx_bit_reg == 3'd0) ? tx_src : tx_byte_reg;

  // output shifter, driven after falling clock, msb first
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      so_reg      <= 1'b0;
      so_oe_reg   <= 1'b0;
      tx_bit_reg  <= 3'd0;
      tx_byte_reg <= 8'h00;
    end
    else if (!cs_low)
    begin
      so_oe_reg  <= 1'b0;
      tx_bit_reg <= 3'd0;
    end
    else if (sck_fall && (state_reg == ST_RSTAT || state_reg == ST_RDATA))
    begin
      so_reg      <= tx_cur[7];
      so_oe_reg   <= 1'b1;
      tx_byte_reg <= {tx_cur[6:0], 1'b0};
      tx_bit_reg  <= tx_bit_reg + 3'd1;
    end

  assign so_out         = so_reg;
  assign so_oe_out      = so_oe_reg;
  assign dog_period_out = dog_reg;
  assign busy_out       = busy_reg;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // last cycle of a status write; the new bits land at the next edge
  sequence s_stat_end;
    busy_end && !busy_arr_reg;
  endsequence

  sequence s_set_cmd;
    pop && state_reg == ST_OPC && rx_byte == OP_SET_LATCH && !wp_low && !busy_end;
  endsequence

  AST_LATCH_SET: assert property (s_set_cmd |=> latch_reg)
    else $error("set command did not set latch");
  AST_LATCH_CLR: assert property (pop && state_reg == ST_OPC
    && rx_byte == OP_CLR_LATCH |=> !latch_reg)
    else $error("clear command did not clear latch");
  AST_WP_CLR: assert property (wp_low |=> !latch_reg)
    else $error("latch stayed set with protect pin low");
  AST_END_CLR: assert property ($fell(busy_reg) |-> !latch_reg)
    else $error("latch survived a write cycle");
  AST_COMMIT_GATED: assert property ($rose(busy_reg) |-> $past(latch_reg) && !$past(wp_low))
    else $error("write started without latch or with pin low");
  AST_STATUS_BITS: assert property (stat_word[7:6] == 2'b00 && stat_word[BUSY_POS] == busy_out
    && stat_word[LATCH_POS] == latch_reg)
    else $error("status word layout wrong");
  AST_BUSY_HOLD: assert property (busy_reg && busy_cnt_reg != 16'h0000 |=> busy_reg)
    else $error("busy dropped before count ended");
  AST_STAT_APPLY: assert property (s_stat_end |=>
    level_reg == stat_data_reg[LEVEL_POS+:2] && dog_reg == stat_data_reg[DOG_POS+:2])
    else $error("status write not applied");
  AST_READ_WRAP: assert property (sck_fall && state_reg == ST_RDATA && tx_bit_reg == 3'd7
    && addr_reg == 9'h1ff && !frame_end |=> addr_reg == 9'h000)
    else $error("read address did not wrap");
  AST_SO_RELEASE: assert property (!cs_low |=> !so_oe_out ##1 !so_oe_out || cs_low)
    else $error("output driven outside a frame");

endmodule : spi_eeprom_command_protect

//--- logic/_unused_guard_placeholder.sv
`timescale 1ns/1ps

//--- bench/spi_host_model.sv
`timescale 1ns/1ps
// spi host model: mode 0, msb first, sck stands still low between frames
module spi_host_model
(
  // clock
  input  wire logic  clk_in,
  // from the device
  input  wire logic  so_in,
  input  wire logic  so_oe_in,
  // link pins
  output logic       sck_out,
  output logic       cs_n_out,
  output logic       si_out,
  // bytes read back while the device drove so
  output logic [7:0] rx_out,
  output logic       rx_vld_out
);
  logic oe_seen; // so enabled at the last sample

  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    rx_out = 8'h00;
    rx_vld_out = 1'b0;
    oe_seen = 1'b0;
  end

  // released data line toggles, so a stale level is never trusted
  always @(posedge clk_in)
    if (cs_n_out) si_out <= ~si_out;

  // select, with settle time for the device synchroniser
  task automatic sel();
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : sel

  // deselect a few clocks after the last fall, then idle gap
  task automatic desel();
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : desel

  // nb bits of one byte; 1 to 7 break byte alignment on purpose
  task automatic xfer(input logic [7:0] b, input int nb);
    logic [7:0] sh;
    sh = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      si_out <= b[i]; // msb first
      repeat (10) @(posedge clk_in);
      sck_out <= 1'b1; // si held across the rise
      sh[i] = so_oe_in ? so_in : ~so_in; // released line shows no stale level
      oe_seen = so_oe_in;
      repeat (10) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    if (nb == 8 && oe_seen)
    begin
      rx_out <= sh;
      rx_vld_out <= 1'b1;
      @(posedge clk_in);
      rx_vld_out <= 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  localparam int WCYC = 400; // long enough to read status while busy
  logic        clk_in;
  logic        rst_n_in;
  logic        wp_n_in;
  logic        sck, cs_n, si, so, so_oe, busy, rx_vld;
  logic [1:0]  dog;
  logic [7:0]  rx;
  logic [7:0]  exp_q[$]; // expected read bytes, oldest first
  logic [7:0]  msk_q[$]; // bits that count in each
  logic [7:0]  mem[512]; // reference array
  logic [16:0] lfsr;
  logic [8:0]  base[3] = '{9'h000, 9'h100, 9'h1f0};
  logic [1:0]  lv;
  logic [8:0]  a;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  spi_eeprom_command_protect #(.WRITE_CYCLES(WCYC)) u_spi_eeprom_command_protect (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(so_oe), .wp_n_in(wp_n_in), .dog_period_out(dog), .busy_out(busy));
  spi_host_model u_spi_host_model (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .rx_out(rx), .rx_vld_out(rx_vld));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction : rnd

  // locked range per protection level
  function automatic logic locked(input logic [1:0] l, input logic [8:0] x);
    return (l == 2'b11) || (l == 2'b10 && x[8]) || (l == 2'b01 && x[8:7] == 2'b11);
  endfunction : locked

  task automatic cmp(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
    begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic note(input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask : note

  task automatic tx(input logic [7:0] b);
    u_spi_host_model.xfer(b, 8);
  endtask : tx

  task automatic op1(input logic [7:0] op);
    u_spi_host_model.sel();
    tx(op);
    u_spi_host_model.desel();
  endtask : op1

  task automatic rd_stat(input logic [7:0] e, input logic [7:0] m, input int n);
    u_spi_host_model.sel();
    tx(OP_RD_STAT);
    for (int i = 0; i < n; i++)
    begin
      note(e, m);
      tx(rnd());
    end
    u_spi_host_model.desel();
  endtask : rd_stat

  // bounded wait for the write cycle to end
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (8) @(posedge clk_in);
    while (busy !== 1'b0 && k < 2 * WCYC)
    begin
      @(posedge clk_in);
      k++;
    end
    cmp(8'h00, {7'h00, busy}, 8'hff);
  endtask : wait_idle

  task automatic wr_stat(input logic [7:0] d, input logic l);
    if (l) op1(OP_SET_LATCH);
    u_spi_host_model.sel();
    tx(OP_WR_STAT);
    tx(d);
    u_spi_host_model.desel();
  endtask : wr_stat

  // page write of n random bytes; en says whether it may land
  task automatic wr_arr(input logic [8:0] x, input int n, input logic en);
    logic [7:0] d;
    op1(OP_SET_LATCH);
    u_spi_host_model.sel();
    tx(OP_WRITE | {4'h0, x[8], 3'h0});
    tx(x[7:0]);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      tx(d);
      if (en) mem[{x[8:4], x[3:0] + 4'(i)}] = d;
    end
    u_spi_host_model.desel();
    wait_idle();
  endtask : wr_arr

  task automatic rd_arr(input logic [8:0] x, input int n);
    u_spi_host_model.sel();
    tx(OP_READ | {4'h0, x[8], 3'h0});
    tx(x[7:0]);
    for (int i = 0; i < n; i++)
    begin
      note(mem[x + 9'(i)], 8'hff);
      tx(rnd());
    end
    u_spi_host_model.desel();
  endtask : rd_arr

  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // every byte the device shifts out meets the oldest note
  always @(posedge clk_in)
    if (rx_vld === 1'b1)
      cmp(exp_q.size() ? exp_q.pop_front() : 8'hxx, rx, msk_q.size() ? msk_q.pop_front() : 8'hff);

  // hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    lfsr = 17'h11bb9;
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    cmp(8'h03, {6'h00, dog}, 8'hff);
    rd_stat(STATUS_RESET, 8'hff, 2);
    op1(OP_SET_LATCH);
    rd_stat(8'h32, 8'hff, 1);
    op1(OP_CLR_LATCH);
    rd_stat(8'h30, 8'hff, 1);
    // status write in the latch frame, then with latch clear: both dropped
    u_spi_host_model.sel();
    tx(OP_SET_LATCH);
    wr_stat(8'h00, 1'b0);
    op1(OP_CLR_LATCH);
    wr_stat(8'h00, 1'b0);
    wait_idle();
    rd_stat(8'h30, 8'hff, 1);
    // fill three pages, then wrap reads and a wrapping page write
    for (int k = 0; k < 3; k++) wr_arr(base[k], 16, 1'b1);
    rd_arr(9'h1fe, 4);
    rd_arr(9'h100, 2);
    wr_arr(9'h0ee, 18, 1'b1);
    rd_arr(9'h0e0, 16);
    // every level and period, with a write attempt in each region
    for (int l = 1; l < 5; l++)
    begin
      lv = 2'(l);
      wr_stat({2'b11, lv, lv, 2'b11}, 1'b1);
      rd_stat(8'h01, 8'h01, 1);
      wait_idle();
      rd_stat({2'b00, lv, lv, 2'b00}, 8'hff, 1);
      cmp({6'h00, lv}, {6'h00, dog}, 8'hff);
      for (int k = 0; k < 3; k++)
      begin
        a = base[k] | 9'h005;
        wr_arr(a, 1, !locked(lv, a));
        rd_arr(a, 1);
      end
    end
    // select rise before any data, then mid-byte: no write cycle
    for (int j = 0; j < 2; j++)
    begin
      op1(OP_SET_LATCH);
      u_spi_host_model.sel();
      tx(OP_WRITE);
      tx(8'h05);
      if (j == 1) tx(8'ha5);
      u_spi_host_model.xfer(8'h5a, 5 * j);
      u_spi_host_model.desel();
      repeat (8) @(posedge clk_in);
      cmp(8'h00, {7'h00, busy}, 8'hff);
    end
    rd_arr(9'h005, 1);
    // protect pin low clears the latch and blocks the write
    wp_n_in <= 1'b0;
    wr_stat(8'h3c, 1'b1);
    wp_n_in <= 1'b1;
    wait_idle();
    rd_stat(8'h00, 8'hff, 1);
    repeat (40) @(posedge clk_in);
    cmp(8'h00, 8'(exp_q.size()), 8'hff);
    print_verdict();
  end
endmodule : tb
